// ---- core/lar_map.vh ----
`ifndef LAR_MAP_VH
`define LAR_MAP_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define LAR_OFF_CTRL 12'h000
`define LAR_OFF_DELAY 12'h004
`define LAR_OFF_HI1 12'h008
`define LAR_OFF_LO1 12'h00C
`define LAR_OFF_HI2 12'h010
`define LAR_OFF_LO2 12'h014
`define LAR_OFF_STAT 12'h018
`define LAR_OFF_IRQ_STAT 12'h01C
`define LAR_OFF_IRQ_MASK 12'h020
`define LAR_OFF_LEVEL 12'h024
// ****************************************************************
// Control fields: bit0 ch1 low-acting, bit1 ch2 low-acting,
// bit2 ch1 failsafe, bit3 ch2 failsafe, bit4 restore defaults
// ****************************************************************
`define LAR_CTRL_LOW_ACT 0
`define LAR_CTRL_FAILSAFE 2
`define LAR_CTRL_RESTORE 4
`define LAR_CTRL_RST 4'hC
// ****************************************************************
// Defaults, level in tenths of percent
// ****************************************************************
`define LAR_HI1_RST 10'h190
`define LAR_HI2_RST 10'h320
`define LAR_LO1_RST 10'h0C8
`define LAR_LO2_RST 10'h258
`define LAR_LEVEL_FULL 10'h3E8
`define LAR_DELAY_RST 10'h000
`define LAR_DELAY_MAX 10'h258
// ****************************************************************
// Timing
// ****************************************************************
`define LAR_CLK_HZ 25000000
`define LAR_SEC_NS 1000000000
`define LAR_CLK_NS 40
`endif

// ---- core/lar_relay_ctrl.v ----
// Operation
// - Two independent alarm channels with own relays
// - One delay value shared by both channels
// - High setpoints default 40% and 80%
// - Low setpoints default 20% and 60%
// - Alarm after condition persists delay, 0-600s
// - High acting: set above high, clear below low
// - Low acting: set below low, clear above high
// - Between setpoints alarm state is held
// - Default action is high acting
// - Non-failsafe: alarm energizes relay, LED on
// - Failsafe: relay energized idle, dropped in alarm
// - Default failsafe enabled
// - Level scale 0 oil to 100 water
//
// Local design decisions: register access over APB and the placing of the registers.
`include "lar_map.vh"
`timescale 1ns/10ps
`default_nettype none
module lar_relay_ctrl #(
    parameter integer NCH = 2,
    parameter integer SEC_CYCLES = `LAR_SEC_NS / `LAR_CLK_NS
)(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [9:0] level,
    output reg [1:0] relay_coil,
    output reg [1:0] alarm_led,
    output reg irq
);
// ****************************************************************
// Register file
// ****************************************************************
reg [3:0] ctrl_q;
reg [9:0] delay_q;
reg [9:0] hi_q [0:1];
reg [9:0] lo_q [0:1];
reg [1:0] alarm_q;
reg [3:0] irq_stat_q;
reg [3:0] irq_mask_q;
reg [3:0] irq_stat_d;
reg [31:0] rdata_d;
reg addr_ok;
wire acc = psel & ~penable;
wire wr = psel & penable & pready & pwrite;
wire restore = wr && (paddr == `LAR_OFF_CTRL) &&
    pwdata[`LAR_CTRL_RESTORE];
wire [1:0] set_ev;
wire [1:0] clr_ev;
always @*
begin
    rdata_d = 32'h0;
    addr_ok = 1'b1;
    case (paddr)
        `LAR_OFF_CTRL: rdata_d = {28'h0, ctrl_q};
        `LAR_OFF_DELAY: rdata_d = {22'h0, delay_q};
        `LAR_OFF_HI1: rdata_d = {22'h0, hi_q[0]};
        `LAR_OFF_LO1: rdata_d = {22'h0, lo_q[0]};
        `LAR_OFF_HI2: rdata_d = {22'h0, hi_q[1]};
        `LAR_OFF_LO2: rdata_d = {22'h0, lo_q[1]};
        `LAR_OFF_STAT: rdata_d = {28'h0, relay_coil, alarm_q};
        `LAR_OFF_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
        `LAR_OFF_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
        `LAR_OFF_LEVEL: rdata_d = {22'h0, level};
        default: addr_ok = 1'b0;
    endcase
end
// Zero-wait-state slave: answer in the cycle after setup
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0;
    end
    else
    begin
        pready <= acc;
        pslverr <= acc & ~addr_ok;
        prdata <= (acc & ~pwrite) ? rdata_d : 32'h0;
    end
end
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl_q <= `LAR_CTRL_RST;
        delay_q <= `LAR_DELAY_RST;
        hi_q[0] <= `LAR_HI1_RST;
        hi_q[1] <= `LAR_HI2_RST;
        lo_q[0] <= `LAR_LO1_RST;
        lo_q[1] <= `LAR_LO2_RST;
        irq_mask_q <= 4'h0;
    end
    else if (restore)
    begin
        ctrl_q <= `LAR_CTRL_RST;
        delay_q <= `LAR_DELAY_RST;
        hi_q[0] <= `LAR_HI1_RST;
        hi_q[1] <= `LAR_HI2_RST;
        lo_q[0] <= `LAR_LO1_RST;
        lo_q[1] <= `LAR_LO2_RST;
    end
    else if (wr)
    begin
        case (paddr)
            `LAR_OFF_CTRL: ctrl_q <= pwdata[3:0];
            `LAR_OFF_DELAY: delay_q <= (pwdata[9:0] > `LAR_DELAY_MAX) ?
                `LAR_DELAY_MAX : pwdata[9:0];
            `LAR_OFF_HI1: hi_q[0] <= pwdata[9:0];
            `LAR_OFF_LO1: lo_q[0] <= pwdata[9:0];
            `LAR_OFF_HI2: hi_q[1] <= pwdata[9:0];
            `LAR_OFF_LO2: lo_q[1] <= pwdata[9:0];
            `LAR_OFF_IRQ_MASK: irq_mask_q <= pwdata[3:0];
            default: ;
        endcase
    end
end
// ****************************************************************
// Interrupts: alarm set and clear events, write one to clear
// ****************************************************************
always @*
begin
    irq_stat_d = irq_stat_q;
    if (wr && (paddr == `LAR_OFF_IRQ_STAT))
        irq_stat_d = irq_stat_q & ~pwdata[3:0];
    irq_stat_d = irq_stat_d | {clr_ev, set_ev};
end
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_stat_q <= 4'h0;
        irq <= 1'b0;
    end
    else
    begin
        irq_stat_q <= irq_stat_d;
        irq <= |(irq_stat_d & irq_mask_q);
    end
end
// ****************************************************************
// Seconds tick shared by both channels
// ****************************************************************
reg [31:0] presc_q;
reg tick_q;
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        presc_q <= 32'h0;
        tick_q <= 1'b0;
    end
    else if (presc_q == SEC_CYCLES - 1)
    begin
        presc_q <= 32'h0;
        tick_q <= 1'b1;
    end
    else
    begin
        presc_q <= presc_q + 32'h1;
        tick_q <= 1'b0;
    end
end
// ****************************************************************
// Alarm channels
// ****************************************************************
genvar g;
generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
        reg [9:0] secs_q;
        // Level scale: 0 oil, full scale water
        wire above = level > hi_q[g];
        wire below = level < lo_q[g];
        wire low_act = ctrl_q[`LAR_CTRL_LOW_ACT + g];
        wire fsafe = ctrl_q[`LAR_CTRL_FAILSAFE + g];
        wire set_c = low_act ? below : above;
        wire clr_c = low_act ? above : below;
        wire expired = (secs_q >= delay_q);
        assign set_ev[g] = ~alarm_q[g] & set_c & expired;
        assign clr_ev[g] = alarm_q[g] & clr_c;
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                secs_q <= 10'h0;
                alarm_q[g] <= 1'b0;
                alarm_led[g] <= 1'b0;
                relay_coil[g] <= 1'b1;
            end
            else
            begin
                if (!set_c || alarm_q[g])
                    secs_q <= 10'h0;
                else if (tick_q && !expired)
                    secs_q <= secs_q + 10'h1;
                if (set_ev[g])
                    alarm_q[g] <= 1'b1;
                else if (clr_ev[g])
                    alarm_q[g] <= 1'b0;
                alarm_led[g] <= set_ev[g] |
                    (alarm_q[g] & ~clr_ev[g]);
                relay_coil[g] <= fsafe ^ (set_ev[g] |
                    (alarm_q[g] & ~clr_ev[g]));
            end
        end
    end
endgenerate
endmodule // lar_relay_ctrl
`default_nettype wire

// ---- sim/lar_level_src.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lar_map.vh"
module lar_level_src (
    input wire logic pclk,
    input wire logic [9:0] target,
    output logic [9:0] level
);
    // Level in tenths of percent, clipped at all water
    always @(posedge pclk)
        level <= (target > `LAR_LEVEL_FULL) ? `LAR_LEVEL_FULL : target;
endmodule // lar_level_src
`default_nettype wire

// ---- sim/lar_relay_ctrl_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module lar_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [1:0] relay_coil,
    input wire [1:0] alarm_led,
    input wire irq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_reset_idle: assert property ($rose(presetn) |->
        alarm_led == 2'b00 && relay_coil == 2'b11 && !irq) else $error("reset");
    chk_led_relay_a: assert property ($changed(alarm_led[0]) &&
        !$past(psel && penable && pready) |-> $changed(relay_coil[0]))
        else $error("a");
    chk_led_relay_b: assert property ($changed(alarm_led[1]) &&
        !$past(psel && penable && pready) |-> $changed(relay_coil[1]))
        else $error("b");
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready");
    chk_ready_once: assert property (pready |=> !pready) else $error("long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("err");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("rdata");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("stray");
    cover property ($rose(alarm_led[1]));
    cover property (pslverr);
    cover property ($rose(irq));
endmodule // lar_chk
bind lar_relay_ctrl lar_chk u_chk (.*);
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lar_map.vh"
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [9:0] target = 10'h000;
    logic [31:0] rv [6] = '{32'hC, 32'h0, 32'h190, 32'hC8, 32'h320, 32'h258};
    logic [32:0] q [$];
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [1:0] relay_coil, alarm_led;
    wire [9:0] level;
    int err_total = 0, n_checks = 0, cyc = 0, i;
    always #20 pclk = ~pclk;
    lar_relay_ctrl #(.SEC_CYCLES(10)) uut (.*);
    lar_level_src u_src (.*);
    task chk(input [32:0] s, input [32:0] e);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected at %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task xfer(input [11:0] a, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (!pready);
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input [11:0] a, input [32:0] e);
        q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask
    task pause(input int n, input [4:0] e);
        repeat (n) @(posedge pclk);
        chk({28'h0, irq, alarm_led, relay_coil}, {28'h0, e});
    endtask
    // ****
    // Read results
    // ****
    always @(posedge pclk)
        if (pready && !pwrite)
            chk({pslverr, prdata}, q.pop_front());
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            end_of_test;
        end
    end
    initial
    begin
        i = $urandom(84866);
        repeat (10) @(posedge pclk);
        presetn <= 1;
        pause(1, 5'h03);
        for (i = 0; i < 6; i++)
            rd(12'(i * 4), {1'b0, rv[i]});
        rd(12'h040, 33'h100000000);
        xfer(`LAR_OFF_DELAY, 1'b1, 32'h3FF);
        rd(`LAR_OFF_DELAY, 33'h258);
        xfer(`LAR_OFF_LO1, 1'b1, 32'h50);
        xfer(`LAR_OFF_CTRL, 1'b1, 32'h10);
        rd(`LAR_OFF_LO1, 33'hC8);
        rd(`LAR_OFF_DELAY, 33'h0);
        xfer(`LAR_OFF_DELAY, 1'b1, 32'h0);
        xfer(`LAR_OFF_IRQ_MASK, 1'b1, 32'h1);
        $display("registers done");
        target <= 10'(401 + $urandom % 399);
        pause(4, 5'h16);
        target <= 10'h12C;
        pause(4, 5'h16);
        target <= 10'h064;
        pause(4, 5'h13);
        xfer(`LAR_OFF_IRQ_STAT, 1'b1, 32'hF);
        pause(3, 5'h03);
        target <= 10'h12C;
        xfer(`LAR_OFF_CTRL, 1'b1, 32'h9);
        target <= 10'($urandom % 200);
        pause(4, 5'h17);
        target <= 10'h384;
        pause(4, 5'h18);
        $display("actions done");
        xfer(`LAR_OFF_IRQ_MASK, 1'b1, 32'h0);
        xfer(`LAR_OFF_DELAY, 1'b1, 32'h3);
        xfer(`LAR_OFF_CTRL, 1'b1, 32'h0);
        pause(15, 5'h0A);
        target <= 10'h064;
        pause(4, 5'h00);
        target <= 10'h384;
        pause(16, 5'h00);
        pause(20, 5'h0F);
        $display("delay done");
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
